//--- rtl/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_in,    // Clock
  input  wire logic             rst_in,    // Sync reset
  input  wire logic [WIDTH-1:0] wr_data_in, // Write word
  input  wire logic             wr_valid_in, // Write request
  output logic                  wr_ready_out, // Space free
  output logic [WIDTH-1:0]      rd_data_out, // Head word
  output logic                  rd_valid_out, // Data present
  input  wire logic             rd_ready_in   // Drain accepts
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_state_type;

  fifo_state_type   st_r;
  fifo_state_type   st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic             push;
  logic             pop;

  // Handshake
  assign wr_ready_out = (st_r.cnt != (AW+1)'(DEPTH));
  assign rd_valid_out = (st_r.cnt != '0);
  assign rd_data_out  = mem_r[st_r.rp];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  // Pointer update
  always_comb
  begin
    st_nxt = st_r;
    if (push)
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    if (pop)
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
    if (push)
      mem_r[st_r.wp] <= wr_data_in;
  end
endmodule

//--- rtl/caller_line_data_acquisition.sv
// Summary of operation
// [RULE1] Ring valid drives ring_valid_n low
// [RULE2] Ring validity from sense B duty cycle
// [RULE3] Sense A plus timing powers ring analysis
// [RULE4] Raw output carries entire demodulated stream
// [RULE5] Validated output omits seizure and mark
// [RULE6] Controller qualifies data after ring timing
// [RULE7] Controller holds power-up high 10 us
// [RULE8] Controller samples validated data into bytes
// [RULE9] Start, eight bits LSB first, stop, 1200 baud
// [RULE10] Preamble: alternating seizure then mark run
// [RULE11] Controller checks two's complement checksum
// [RULE12] Controller synchronises inputs before use
`timescale 1ns/1ps
module caller_line_data_acquisition #(
  parameter int unsigned BIT_CYCLES      = cid_pkg::BIT_CYCLES,      // Clocks per line bit
  parameter int unsigned RING_WIN_CYCLES = cid_pkg::RING_WIN_CYCLES, // Ring window length
  parameter int unsigned RING_HI_MIN     = cid_pkg::RING_HI_MIN,     // Least high count
  parameter int unsigned RING_HI_MAX     = cid_pkg::RING_HI_MAX      // Most high count
) (
  input  wire logic clk_in,          // 40 MHz clock
  input  wire logic rst_in,          // Sync reset, active high
  input  wire logic power_up_n,      // Power-up request, active low
  input  wire logic ring_sense_in_a, // Ring presence comparator
  input  wire logic ring_sense_in_b, // Ring duty cycle comparator
  input  wire logic ring_timing_n,   // Ring timing, low during ring
  input  wire logic line_bit_in,     // Sliced FSK bit from line front end
  output logic      ring_valid_n,    // Valid ring, active low
  output logic      unfiltered_data_out, // Raw demodulated stream
  output logic      validated_data_out,  // Validated stream
  output logic      fifo_full_out    // Byte buffer is full
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]              pu_s;
    logic [1:0]              ra_s;
    logic [1:0]              rb_s;
    logic [1:0]              rt_s;
    logic [1:0]              ln_s;
    logic                    ring_pwr;
    logic [cid_pkg::CNT_W-1:0] win_cnt;
    logic [cid_pkg::CNT_W-1:0] hi_cnt;
    logic [2:0]              good_wins;
    logic [2:0]              idle_wins;
    logic                    ring_ok;
    logic                    raw;
    logic [cid_pkg::CNT_W-1:0] bit_cnt;
    logic                    rx_act;
    cid_pkg::rx_phase_type   phase;
    logic [8:0]              run;
    logic                    last_bit;
    logic [2:0]              bit_idx;
    logic [7:0]              shreg;
    logic [7:0]              tx_byte;
    logic [3:0]              tx_pos;
    logic                    tx_busy;
    logic [cid_pkg::CNT_W-1:0] tx_cnt;
    logic                    cooked;
  } acq_state_type;

  acq_state_type st_r;
  acq_state_type st_nxt;

  logic       push_valid;
  logic       push_ready;
  logic [7:0] head_byte;
  logic       head_valid;
  logic       head_take;
  logic       pwr_on;
  logic       ring_hi;
  logic       line_bit;
  logic       bit_tick;
  logic       tx_tick;

  // ****************************************************************
  // Byte buffer between validation and the validated output
  // ****************************************************************
  byte_fifo #(
    .WIDTH (cid_pkg::BYTE_W),
    .DEPTH (cid_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_data_in   (st_r.shreg),
    .wr_valid_in  (push_valid),
    .wr_ready_out (push_ready),
    .rd_data_out  (head_byte),
    .rd_valid_out (head_valid),
    .rd_ready_in  (head_take)
  );

  // Synchronised views and ticks
  assign pwr_on   = ~st_r.pu_s[1];
  assign ring_hi  = st_r.rb_s[1];
  assign line_bit = st_r.ln_s[1];
  assign bit_tick = st_r.rx_act && (st_r.bit_cnt == cid_pkg::CNT_W'(BIT_CYCLES - 1));
  assign tx_tick  = st_r.tx_cnt == cid_pkg::CNT_W'(BIT_CYCLES - 1);
  assign head_take = head_valid && !st_r.tx_busy;
  assign push_valid = bit_tick && (st_r.phase == cid_pkg::PH_STOP) && line_bit;

  // Outputs from flip-flops, full flag decoded from the buffer count
  assign ring_valid_n        = ~st_r.ring_ok;   // [RULE1]
  assign unfiltered_data_out = st_r.raw;
  assign validated_data_out  = st_r.cooked;
  assign fifo_full_out       = ~push_ready;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    // Two-stage synchronisers for pins
    st_nxt.pu_s = {st_r.pu_s[0], power_up_n};
    st_nxt.ra_s = {st_r.ra_s[0], ring_sense_in_a};
    st_nxt.rb_s = {st_r.rb_s[0], ring_sense_in_b};
    st_nxt.rt_s = {st_r.rt_s[0], ring_timing_n};
    st_nxt.ln_s = {st_r.ln_s[0], line_bit_in};

    // Ring analysis power: sense A with timing low wakes it
    if (!pwr_on)
      st_nxt.ring_pwr = 1'b0;
    else if (st_r.ra_s[1] && !st_r.rt_s[1])
      st_nxt.ring_pwr = 1'b1;   // [RULE3]

    // Duty cycle measurement over fixed windows on sense B only
    if (!st_r.ring_pwr)
    begin
      st_nxt.win_cnt   = '0;
      st_nxt.hi_cnt    = '0;
      st_nxt.good_wins = '0;
      st_nxt.idle_wins = '0;
      st_nxt.ring_ok   = 1'b0;
    end
    else if (st_r.win_cnt == cid_pkg::CNT_W'(RING_WIN_CYCLES - 1))
    begin
      st_nxt.win_cnt = '0;
      st_nxt.hi_cnt  = '0;
      if (st_r.hi_cnt >= cid_pkg::CNT_W'(RING_HI_MIN) &&
          st_r.hi_cnt <= cid_pkg::CNT_W'(RING_HI_MAX))
      begin
        st_nxt.idle_wins = '0;
        if (st_r.good_wins == 3'(cid_pkg::RING_WINS - 1))
          st_nxt.ring_ok = 1'b1;   // [RULE2]
        else
          st_nxt.good_wins = st_r.good_wins + 1'b1;
      end
      else
      begin
        st_nxt.good_wins = '0;
        if (st_r.idle_wins == 3'(cid_pkg::RING_IDLE_WINS - 1))
          st_nxt.ring_ok = 1'b0;
        else
          st_nxt.idle_wins = st_r.idle_wins + 1'b1;
      end
    end
    else
    begin
      st_nxt.win_cnt = st_r.win_cnt + 1'b1;
      if (ring_hi)
        st_nxt.hi_cnt = st_r.hi_cnt + 1'b1;
    end

    // Raw output mirrors every demodulated bit
    st_nxt.raw = line_bit;   // [RULE4]

    // Bit timing: start on the first 1-to-0 edge, sample mid-bit
    if (!pwr_on)
    begin
      st_nxt.rx_act = 1'b0;
      st_nxt.phase  = cid_pkg::PH_SEIZE;
      st_nxt.run    = '0;
    end
    else if (!st_r.rx_act)
    begin
      if (!line_bit)
      begin
        st_nxt.rx_act  = 1'b1;
        st_nxt.bit_cnt = cid_pkg::CNT_W'(BIT_CYCLES / 2);
      end
    end
    else
      st_nxt.bit_cnt = bit_tick ? '0 : st_r.bit_cnt + 1'b1;

    // Preamble tracking and byte framing
    if (bit_tick)
    begin
      st_nxt.last_bit = line_bit;
      case (st_r.phase)
        cid_pkg::PH_SEIZE:
        begin
          // Alternating bits count as seizure, a repeated 1 opens mark
          if (line_bit && st_r.last_bit && st_r.run != '0)
          begin
            st_nxt.phase = cid_pkg::PH_MARK;   // [RULE10]
            st_nxt.run   = 9'd2;
          end
          else if (line_bit == st_r.last_bit && st_r.run != '0)
            st_nxt.run = '0;
          else
            st_nxt.run = st_r.run + 1'b1;
        end
        cid_pkg::PH_MARK:
        begin
          if (line_bit)
            st_nxt.run = st_r.run + 1'b1;
          else if (st_r.run >= 9'(cid_pkg::MARK_MIN))
          begin
            st_nxt.phase   = cid_pkg::PH_DATA;   // [RULE10]
            st_nxt.bit_idx = '0;
          end
          else
          begin
            st_nxt.phase = cid_pkg::PH_SEIZE;
            st_nxt.run   = '0;
          end
        end
        cid_pkg::PH_START:
        begin
          if (!line_bit)
          begin
            st_nxt.phase   = cid_pkg::PH_DATA;
            st_nxt.bit_idx = '0;
          end
        end
        cid_pkg::PH_DATA:
        begin
          st_nxt.shreg = {line_bit, st_r.shreg[7:1]};   // [RULE9]
          st_nxt.bit_idx = st_r.bit_idx + 1'b1;
          if (st_r.bit_idx == 3'd7)
            st_nxt.phase = cid_pkg::PH_STOP;
        end
        cid_pkg::PH_STOP:
        begin
          // Only stop-framed bytes enter the buffer
          st_nxt.phase = cid_pkg::PH_START;   // [RULE5]
        end
        default:
          st_nxt.phase = cid_pkg::PH_SEIZE;
      endcase
    end

    // Validated output re-sends buffered bytes with framing
    if (!st_r.tx_busy)
    begin
      st_nxt.tx_cnt = '0;
      st_nxt.cooked = 1'b1;
      if (head_take)
      begin
        st_nxt.tx_busy = 1'b1;
        st_nxt.tx_byte = head_byte;
        st_nxt.tx_pos  = '0;
        st_nxt.cooked  = 1'b0;   // [RULE9]
      end
    end
    else if (tx_tick)
    begin
      st_nxt.tx_cnt = '0;
      st_nxt.tx_pos = st_r.tx_pos + 1'b1;
      if (st_r.tx_pos < 4'd8)
        st_nxt.cooked = st_r.tx_byte[st_r.tx_pos[2:0]];   // [RULE5]
      else if (st_r.tx_pos == 4'd8)
        st_nxt.cooked = 1'b1;
      else
        st_nxt.tx_busy = 1'b0;
    end
    else
      st_nxt.tx_cnt = st_r.tx_cnt + 1'b1;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_r        <= '0;
      st_r.pu_s   <= 2'b11;
      st_r.ln_s   <= 2'b11;
      st_r.raw    <= 1'b1;
      st_r.cooked <= 1'b1;
      st_r.last_bit <= 1'b1;
      st_r.phase  <= cid_pkg::PH_SEIZE;
    end
    else
      st_r <= st_nxt;
  end
endmodule

//--- rtl/cid_pkg.sv
package cid_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned BAUD            = 1200;
  localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned CNT_W           = 16;

  // ****************************************************************
  // Preamble figures
  // ****************************************************************
  localparam int unsigned SEIZE_BITS = 300;
  localparam int unsigned MARK_BITS  = 180;
  localparam int unsigned MARK_MIN   = 10;

  // ****************************************************************
  // Ring analysis
  // ****************************************************************
  localparam int unsigned RING_WIN_CYCLES = 40_000;
  localparam int unsigned RING_HI_MIN     = 8_000;
  localparam int unsigned RING_HI_MAX     = 32_000;
  localparam int unsigned RING_WINS       = 3;
  localparam int unsigned RING_IDLE_WINS  = 4;

  // ****************************************************************
  // Data stream
  // ****************************************************************
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned FIFO_DEPTH = 4;

  // Receive phases
  typedef enum logic [2:0] {
    PH_SEIZE,
    PH_MARK,
    PH_START,
    PH_DATA,
    PH_STOP
  } rx_phase_type;

  // Line demodulator outputs carried together
  typedef struct packed {
    logic bit_val;
    logic strobe;
  } line_bit_type;

endpackage

//--- tb/caller_line_data_acquisition_test.sv
`timescale 1ns/1ps
module caller_line_data_acquisition_test;
  logic       clk_in;
  logic       rst_in;
  logic       power_up_n;
  logic       sense_a;
  logic       sense_b;
  logic       timing_n;
  logic       line_bit;
  logic       ring_valid_n;
  logic       raw;
  logic       clean;
  logic [7:0] byte_w;
  logic [7:0] cnt_w;
  logic       sum_ok;
  logic       full;
  // Shortened bit and window times keep the run small
  localparam int unsigned BIT = 200;
  localparam int unsigned WIN = 400;
  int         err_total = 0;
  int         checks = 0;

  caller_line_data_acquisition #(
    .BIT_CYCLES(BIT), .RING_WIN_CYCLES(WIN), .RING_HI_MIN(80), .RING_HI_MAX(320)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .power_up_n(power_up_n),
    .ring_sense_in_a(sense_a), .ring_sense_in_b(sense_b), .ring_timing_n(timing_n),
    .line_bit_in(line_bit), .ring_valid_n(ring_valid_n), .unfiltered_data_out(raw),
    .validated_data_out(clean), .fifo_full_out(full));
  ctrl_model #(.BIT_CYC(BIT)) i_ctrl (
    .clk_in(clk_in), .rst_in(rst_in), .ring_valid_n(ring_valid_n), .data_in(clean),
    .power_up_n(power_up_n), .byte_out(byte_w), .cnt_out(cnt_w), .sum_ok_out(sum_ok));

  // Clock and watchdog
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial
  begin
    #1_000_000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: bit mismatch", $time);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: byte mismatch", $time);
    end
  endtask
  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One line bit on the bit grid, raw echo checked mid-bit
  task automatic send_bit(input logic b, input logic quiet);
    line_bit = b;
    repeat (BIT / 2) @(posedge clk_in);
    #2;
    check_bit(raw, b);
    if (quiet)
      check_bit(clean, 1'b1);
    repeat (BIT - BIT / 2) @(posedge clk_in);
    #1;
  endtask
  task automatic send_byte(input logic [7:0] d);
    send_bit(1'b0, 1'b0);
    for (int i = 0; i < 8; i++)
      send_bit(d[i], 1'b0);
    send_bit(1'b1, 1'b0);
  endtask

  // Duty-cycle ring raises then drops ring valid
  task automatic t_ring();
    sense_a = 1'b1;
    timing_n = 1'b0;
    for (int n = 0; n < 200_000 && ring_valid_n !== 1'b0; n++)
    begin
      @(posedge clk_in);
      #1;
      if (n % 5 == 0)
        sense_b = ~sense_b;
    end
    check_bit(ring_valid_n, 1'b0);
    sense_a = 1'b0;
    sense_b = 1'b0;
    timing_n = 1'b1;
    for (int n = 0; n < 200_000 && ring_valid_n !== 1'b1; n++)
      @(posedge clk_in);
    #1;
    check_bit(ring_valid_n, 1'b1);
    $display("Test ring done");
  endtask

  // Preamble then two bytes whose sum is zero
  task automatic t_frame();
    for (int n = 0; n < 15; n++)
      send_bit(n > 3 || n % 2 == 1, 1'b1);
    send_byte(8'h5A);
    send_byte(8'hA6);
    for (int n = 0; n < 12 * BIT && cnt_w !== 8'h02; n++)
      @(posedge clk_in);
    check_byte(cnt_w, 8'h02);
    check_byte(byte_w, 8'hA6);
    check_bit(sum_ok, 1'b1);
    check_bit(full, 1'b0);
    $display("Test frame done");
  endtask

  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    sense_a = 1'b0;
    sense_b = 1'b0;
    timing_n = 1'b1;
    line_bit = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_ring();
    t_frame();
    conclude();
  end
endmodule

//--- tb/cld_props.sv
`timescale 1ns/1ps
module cld_props #(
  parameter int unsigned BIT_CYC = cid_pkg::BIT_CYCLES,     // Clocks per line bit
  parameter int unsigned WIN_CYC = cid_pkg::RING_WIN_CYCLES // Ring window length
) (
  input wire logic clk_in,              // Clock
  input wire logic rst_in,              // Reset
  input wire logic power_up_n,          // Power-up
  input wire logic ring_sense_in_b,     // Duty sense
  input wire logic line_bit_in,         // Line bit
  input wire logic ring_valid_n,        // Ring valid
  input wire logic unfiltered_data_out, // Raw stream
  input wire logic validated_data_out,  // Clean stream
  input wire logic fifo_full_out        // Full
);
  localparam int BIT = int'(BIT_CYC);
  int   up_r;
  int   age_r;
  logic b_r;
  int   run_r;
  logic mark_r;
  int   low_r;

  // Span counters
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      up_r   <= 0;
      age_r  <= 0;
      run_r  <= 0;
      mark_r <= 1'b0;
      low_r  <= 0;
    end
    else
    begin
      up_r   <= (up_r < 7) ? up_r + 1 : 7;
      age_r  <= (ring_sense_in_b != b_r) ? 0 : ((age_r < 999_999) ? age_r + 1 : age_r);
      run_r  <= unfiltered_data_out ? run_r + 1 : 0;
      mark_r <= mark_r | (run_r >= (int'(cid_pkg::MARK_MIN) - 1) * BIT);
      low_r  <= validated_data_out ? 0 : low_r + 1;
    end
    b_r <= ring_sense_in_b;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_power_off;
    power_up_n [*4];
  endsequence
  property p_reset_idle;
    disable iff (1'b0)
    rst_in |=> ring_valid_n && unfiltered_data_out && validated_data_out && !fifo_full_out;
  endproperty
  property p_raw_delay;
    up_r == 7 |-> unfiltered_data_out == $past(line_bit_in, 3);
  endproperty
  property p_power_off;
    s_power_off |=> ring_valid_n;
  endproperty
  property p_duty;
    $fell(ring_valid_n) |-> age_r < 2 * int'(WIN_CYC);
  endproperty
  property p_hold;
    $fell(ring_valid_n) |=> (!ring_valid_n || power_up_n) [*8];
  endproperty
  property p_quiet;
    $fell(validated_data_out) |-> mark_r;
  endproperty
  property p_bit_time;
    $rose(validated_data_out) |-> (low_r % BIT) == 0;
  endproperty
  property p_low_bound;
    low_r <= 9 * BIT;
  endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("bad reset state");
  a_raw_delay: assert property (p_raw_delay) else $error("raw lag wrong");
  a_power_off: assert property (p_power_off) else $error("ring without power");
  a_duty: assert property (p_duty) else $error("ring without duty");
  a_hold: assert property (p_hold) else $error("ring dropped early");
  a_quiet: assert property (p_quiet) else $error("data before mark");
  a_bit_time: assert property (p_bit_time) else $error("bit time wrong");
  a_low_bound: assert property (p_low_bound) else $error("no stop bit");
endmodule

bind caller_line_data_acquisition cld_props #(
  .BIT_CYC(BIT_CYCLES), .WIN_CYC(RING_WIN_CYCLES)) i_props (
  .clk_in(clk_in), .rst_in(rst_in), .power_up_n(power_up_n),
  .ring_sense_in_b(ring_sense_in_b), .line_bit_in(line_bit_in),
  .ring_valid_n(ring_valid_n), .unfiltered_data_out(unfiltered_data_out),
  .validated_data_out(validated_data_out), .fifo_full_out(fifo_full_out));

//--- tb/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model #(
  parameter int unsigned BIT_CYC = cid_pkg::BIT_CYCLES // Clocks per line bit
) (
  input  wire logic  clk_in,       // Clock
  input  wire logic  rst_in,       // Reset
  input  wire logic  ring_valid_n, // Ring status
  input  wire logic  data_in,      // Clean stream
  output logic       power_up_n,   // Power-up drive
  output logic [7:0] byte_out,     // Last byte
  output logic [7:0] cnt_out,      // Bytes taken
  output logic       sum_ok_out    // Checksum zero
);
  logic [1:0] ring_s_r;
  logic [1:0] data_s_r;
  logic [7:0] sum_r;

  // Two-stage synchronisers
  always_ff @(posedge clk_in)
  begin
    ring_s_r <= {ring_s_r[0], ring_valid_n};
    data_s_r <= {data_s_r[0], data_in};
  end

  // Power-up held high 10 us, then asserted
  initial
  begin
    power_up_n = 1'b1;
    repeat (400) @(posedge clk_in);
    #1;
    power_up_n = 1'b0;
  end

  // Byte capture once a ring was seen
  initial
  begin
    cnt_out = 8'h00;
    sum_r = 8'h00;
    byte_out = 8'h00;
    @(negedge rst_in);
    wait (ring_s_r[1] === 1'b0);
    forever
    begin
      @(posedge clk_in);
      if (data_s_r[1] === 1'b0)
      begin
        repeat (BIT_CYC / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CYC) @(posedge clk_in);
          byte_out[i] = data_s_r[1];
        end
        repeat (BIT_CYC) @(posedge clk_in);
        if (data_s_r[1] === 1'b1)
        begin
          sum_r = sum_r + byte_out;
          cnt_out = cnt_out + 8'h01;
        end
      end
    end
  end
  assign sum_ok_out = (sum_r == 8'h00);
endmodule
